// ===== eeeg_global_regs.sv
// global eee register bank with indirect byte access and lpi request timers
// Notes on behaviour
// - host writes the byte offset, the device moves that byte through the data port.
// - each 16-bit register takes an even offset for bits 15:8 and the odd one for 7:0.
// - a port raises its lpi request once its queue stays empty longer than the wait time.
// - the wait time counts in units of 1.3 ms.
// - the wait time applies only while fast ethernet rate eee is enabled.
// - one wait time setting governs every port.
// - four read-write next-page enables for ports 4 to 1, each resetting to 1.
// - a set enable makes its port exchange next pages, a clear one skips them.
// - a read-only 16-bit wakeup threshold resets to 0x0201.
// - a phy wake longer than the threshold increments the wakeup error count.
module eeeg_global_regs #(
    parameter int NPORT    = 4,
    parameter int UNIT_CYC = eeeg_pkg::WAIT_UNIT_CYC
) (
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire logic [7:0]       indCtrl,
    input  wire logic [7:0]       indAddr,
    input  wire logic             dataWrite,
    input  wire logic [7:0]       dataIn,
    output logic      [7:0]       dataOut,
    input  wire logic             fastEthernetRateEee,
    input  wire logic [NPORT-1:0] transmitQueueEmpty,
    input  wire logic [NPORT-1:0] frameEnqueue,
    output logic      [NPORT-1:0] lpiRequest,
    output logic      [3:0]       nextPageEnable,
    input  wire logic [NPORT-1:0] phyWaking,
    output logic      [15:0]      wakeupErrorCount
);
    // ************************************************************
    // indirect register access
    // ************************************************************
    logic [15:0] waitTime, next_waitTime;
    logic [3:0]  npEn, next_npEn;
    logic        selOk;
    logic [6:0]  wordOfs;
    logic [15:0] rdWord;
    logic [7:0]  next_dataOut;

    assign selOk   = (indCtrl[7:5] == eeeg_pkg::TABLE_EEE)
                   && (indCtrl[3:0] == eeeg_pkg::SEL_GLOBAL);
    assign wordOfs = indAddr[7:1];

    always_comb begin
        next_waitTime = waitTime;
        next_npEn     = npEn;
        rdWord        = 16'h0000;
        unique case (wordOfs)
            eeeg_pkg::OFS_WAIT_HI[7:1]:   rdWord = waitTime;
            eeeg_pkg::OFS_NP_HI[7:1]:     rdWord = {eeeg_pkg::RST_NP_UPPER[15:4], npEn};
            eeeg_pkg::OFS_MINLPI_HI[7:1]: rdWord = eeeg_pkg::RST_MINLPI;
            eeeg_pkg::OFS_THR_HI[7:1]:    rdWord = eeeg_pkg::RST_THR;
            eeeg_pkg::OFS_DIAG_HI[7:1]:   rdWord = eeeg_pkg::RST_DIAG;
            default:                      rdWord = 16'h0000;
        endcase
        // odd offset returns the low byte, even the high byte
        next_dataOut = !selOk ? 8'h00 : (indAddr[0] ? rdWord[7:0] : rdWord[15:8]);
        if (selOk && dataWrite) begin
            if (wordOfs == eeeg_pkg::OFS_WAIT_HI[7:1]) begin
                if (indAddr[0]) begin
                    next_waitTime[7:0] = dataIn;
                end else begin
                    next_waitTime[15:8] = dataIn;
                end
            end
            if (wordOfs == eeeg_pkg::OFS_NP_HI[7:1] && indAddr[0]) begin
                next_npEn = dataIn[3:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            waitTime <= eeeg_pkg::RST_WAIT;
            npEn     <= eeeg_pkg::RST_NP_EN;
            dataOut  <= 8'h00;
        end else begin
            waitTime <= next_waitTime;
            npEn     <= next_npEn;
            dataOut  <= next_dataOut;
        end
    end

    assign nextPageEnable = npEn;

    // ************************************************************
    // unit tick shared by all ports
    // ************************************************************
    // one divider for all ports keeps them in step; the cost is up to one unit of jitter
    logic [31:0] unitCnt, next_unitCnt;
    logic        unitTick;
    assign unitTick = (unitCnt == 32'(UNIT_CYC - 1));
    always_comb begin
        next_unitCnt = unitTick ? 32'h0 : unitCnt + 32'h1;
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            unitCnt <= 32'h0;
        end else begin
            unitCnt <= next_unitCnt;
        end
    end

    // ************************************************************
    // per-port idle timers and wake supervision
    // ************************************************************
    logic [NPORT-1:0] wakeLate;
    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            logic [16:0] idleCnt, next_idleCnt;
            logic        lpi, next_lpi;
            logic [16:0] wakeCnt, next_wakeCnt;
            logic        wakeFlag, next_wakeFlag;
            always_comb begin
                next_idleCnt = idleCnt;
                next_lpi     = lpi;
                // a frame arriving or a non-empty queue restarts the wait
                if (!fastEthernetRateEee || frameEnqueue[p] || !transmitQueueEmpty[p]) begin
                    next_idleCnt = 17'h0;
                    next_lpi     = 1'b0;
                end else if (unitTick && !lpi) begin
                    next_idleCnt = idleCnt + 17'h1;
                end
                // strictly longer than the shared wait time
                if (fastEthernetRateEee && transmitQueueEmpty[p] && !frameEnqueue[p]
                        && idleCnt > {1'b0, waitTime}) begin
                    next_lpi = 1'b1;
                end
                next_wakeFlag = 1'b0;
                // the wake count saturates, so a stuck wake is counted only once
                next_wakeCnt  = phyWaking[p] ? wakeCnt + {16'h0, ~wakeCnt[16]} : 17'h0;
                if (phyWaking[p] && wakeCnt == {1'b0, eeeg_pkg::RST_THR}) begin
                    next_wakeFlag = 1'b1;
                end
            end
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    idleCnt  <= 17'h0;
                    lpi      <= 1'b0;
                    wakeCnt  <= 17'h0;
                    wakeFlag <= 1'b0;
                end else begin
                    idleCnt  <= next_idleCnt;
                    lpi      <= next_lpi;
                    wakeCnt  <= next_wakeCnt;
                    wakeFlag <= next_wakeFlag;
                end
            end
            assign lpiRequest[p] = lpi;
            assign wakeLate[p]   = wakeFlag;
        end
    endgenerate

    // one increment per late port per cycle; count saturates
    logic [15:0] next_errCnt;
    always_comb begin
        next_errCnt = wakeupErrorCount;
        for (int i = 0; i < NPORT; i++) begin
            if (wakeLate[i] && next_errCnt != 16'hFFFF) begin
                next_errCnt = next_errCnt + 16'h1;
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wakeupErrorCount <= 16'h0000;
        end else begin
            wakeupErrorCount <= next_errCnt;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    // port checks watch the first and last port; every port shares one body of logic
    a_wait_write_hi: assert property (@(posedge sys_clk) disable iff (!rstn)
        selOk && dataWrite && indAddr == eeeg_pkg::OFS_WAIT_HI
        |=> waitTime[15:8] == $past(dataIn)) else $error("wait hi byte not stored");
    a_wait_write_lo: assert property (@(posedge sys_clk) disable iff (!rstn)
        selOk && dataWrite && indAddr == eeeg_pkg::OFS_WAIT_HI + 8'h01
        |=> waitTime[7:0] == $past(dataIn)) else $error("wait lo byte not stored");
    a_np_write: assert property (@(posedge sys_clk) disable iff (!rstn)
        selOk && dataWrite && indAddr == eeeg_pkg::OFS_NP_HI + 8'h01
        |=> nextPageEnable == $past(dataIn[3:0])) else $error("np enables not stored");
    a_np_read: assert property (@(posedge sys_clk) disable iff (!rstn)
        selOk && indAddr == eeeg_pkg::OFS_NP_HI + 8'h01
        |=> dataOut == {eeeg_pkg::RST_NP_UPPER[7:4], $past(nextPageEnable)})
        else $error("np enables read back wrong");
    a_thr_read: assert property (@(posedge sys_clk) disable iff (!rstn)
        selOk && indAddr == eeeg_pkg::OFS_THR_HI + 8'h01
        |=> dataOut == 8'h01) else $error("threshold low byte wrong");
    a_sel_block: assert property (@(posedge sys_clk) disable iff (!rstn)
        !selOk && dataWrite |=> $stable(waitTime) && $stable(nextPageEnable))
        else $error("write without selection took effect");
    a_unsel_read: assert property (@(posedge sys_clk) disable iff (!rstn)
        !selOk |=> dataOut == 8'h00) else $error("unselected read not zero");
    a_tick_wrap: assert property (@(posedge sys_clk) disable iff (!rstn)
        unitTick |=> unitCnt == 32'h0) else $error("unit counter did not wrap");
    a_lpi_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
        !fastEthernetRateEee |=> lpiRequest == '0) else $error("lpi without eee");
    a_enq_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
        frameEnqueue[0] |=> !lpiRequest[0]) else $error("lpi after enqueue");
    a_lpi_rise: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(lpiRequest[0]) |-> $past(transmitQueueEmpty[0]) && $past(fastEthernetRateEee))
        else $error("lpi raised with busy queue");
    a_lpi_wait: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(lpiRequest[NPORT-1])
        |-> $past(g_port[NPORT-1].idleCnt) > {1'b0, $past(waitTime)})
        else $error("lpi raised before the wait time");
    a_lpi_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        lpiRequest[0] && fastEthernetRateEee && transmitQueueEmpty[0] && !frameEnqueue[0]
        |=> lpiRequest[0]) else $error("lpi dropped while idle");
    a_wake_err: assert property (@(posedge sys_clk) disable iff (!rstn)
        wakeLate != '0 && wakeupErrorCount != 16'hFFFF
        |=> wakeupErrorCount != $past(wakeupErrorCount)) else $error("wake error not counted");
    a_err_cause: assert property (@(posedge sys_clk) disable iff (!rstn)
        wakeupErrorCount != $past(wakeupErrorCount) |-> $past(wakeLate) != '0)
        else $error("wake error count moved without a late wake");
endmodule : eeeg_global_regs

// ===== eeeg_pkg.sv
// package for the global eee indirect register bank
package eeeg_pkg;
    // ************************************************************
    // indirect access codes
    // ************************************************************
    localparam logic [2:0] TABLE_EEE     = 3'h1;
    localparam logic [3:0] SEL_GLOBAL    = 4'h0;
    localparam logic [7:0] OFS_WAIT_HI   = 8'h32;
    localparam logic [7:0] OFS_NP_HI     = 8'h34;
    localparam logic [7:0] OFS_MINLPI_HI = 8'h36;
    localparam logic [7:0] OFS_THR_HI    = 8'h38;
    localparam logic [7:0] OFS_DIAG_HI   = 8'h3A;
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0] RST_WAIT      = 16'h0010;
    localparam logic [15:0] RST_NP_UPPER  = 16'h6800;
    localparam logic [3:0]  RST_NP_EN     = 4'hF;
    localparam logic [15:0] RST_MINLPI    = 16'h0000;
    localparam logic [15:0] RST_THR       = 16'h0201;
    localparam logic [15:0] RST_DIAG      = 16'h0000;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ      = 100;
    localparam int WAIT_UNIT_US = 1300;
    localparam int WAIT_UNIT_CYC = WAIT_UNIT_US * CLK_MHZ;
endpackage : eeeg_pkg

// ===== tb.sv
// self-checking bench for the global eee register bank
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int UNIT = 4;
    logic        sys_clk, rstn, dataWrite, fastEthernetRateEee;
    logic [7:0]  indCtrl, indAddr, dataIn, dataOut, np;
    logic [3:0]  transmitQueueEmpty, frameEnqueue, lpiRequest, nextPageEnable, phyWaking;
    logic [15:0] wakeupErrorCount, wtExp;
    logic [7:0]  ra, rdat;
    logic [3:0]  enExp;
    int          n_mismatch, checks_done, seed, w, k;
    eeeg_global_regs #(.NPORT(4), .UNIT_CYC(UNIT)) eeeg_global_regs_i (
        .sys_clk(sys_clk), .rstn(rstn), .indCtrl(indCtrl), .indAddr(indAddr),
        .dataWrite(dataWrite), .dataIn(dataIn), .dataOut(dataOut),
        .fastEthernetRateEee(fastEthernetRateEee), .transmitQueueEmpty(transmitQueueEmpty),
        .frameEnqueue(frameEnqueue), .lpiRequest(lpiRequest), .nextPageEnable(nextPageEnable),
        .phyWaking(phyWaking), .wakeupErrorCount(wakeupErrorCount));
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [7:0] expReset(input logic [7:0] ofs);
        case (ofs)
            8'h32:   return eeeg_pkg::RST_WAIT[15:8];
            8'h33:   return eeeg_pkg::RST_WAIT[7:0];
            8'h34:   return eeeg_pkg::RST_NP_UPPER[15:8];
            8'h35:   return {4'h0, eeeg_pkg::RST_NP_EN};
            8'h38:   return eeeg_pkg::RST_THR[15:8];
            8'h39:   return eeeg_pkg::RST_THR[7:0];
            default: return 8'h00;
        endcase
    endfunction : expReset
    function automatic logic [7:0] expByte(input logic [7:0] ofs, input logic [15:0] wt,
                                           input logic [3:0] en);
        case (ofs)
            8'h32:   return wt[15:8];
            8'h33:   return wt[7:0];
            8'h35:   return {4'h0, en};
            default: return expReset(ofs);
        endcase
    endfunction : expByte
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        indAddr = a;
        dataIn = d;
        dataWrite = 1'b1;
        @(negedge sys_clk);
        dataWrite = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        indAddr = a;
        @(negedge sys_clk);
        chk({8'h00, dataOut}, {8'h00, e});
    endtask : rd
    task automatic stop_test;
        $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    // ************************************************************
    // clock, watchdog, sequence
    // ************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (50000) @(posedge sys_clk);
        n_mismatch++;
        stop_test;
    end
    initial begin
        {rstn, dataWrite, fastEthernetRateEee} = 3'h0;
        {indAddr, dataIn, transmitQueueEmpty, frameEnqueue, phyWaking} = '0;
        indCtrl = {eeeg_pkg::TABLE_EEE, 1'b0, eeeg_pkg::SEL_GLOBAL};
        seed = 5589;
        repeat (6) @(negedge sys_clk);
        rstn = 1'b1;
        chk({12'h000, nextPageEnable}, 16'h000F);
        for (int a = 8'h32; a <= 8'h3C; a++) rd(8'(a), expReset(8'(a)));
        for (int a = 8'h36; a <= 8'h39; a++) wr(8'(a), 8'hA5); // read-only places
        rd(8'h36, 8'h00);
        rd(8'h38, 8'h02);
        indCtrl = 8'h40; // other table: ignored and reads 0
        wr(8'h33, 8'h77);
        rd(8'h33, 8'h00);
        indCtrl = 8'h20;
        rd(8'h33, 8'h10);
        np = 8'($random(seed));
        wr(8'h35, np);
        rd(8'h35, {4'h0, np[3:0]});
        chk({12'h000, nextPageEnable}, {12'h000, np[3:0]});
        wr(8'h35, ~np);
        chk({12'h000, nextPageEnable}, {12'h000, ~np[3:0]});
        // random writes over the whole window, each read straight back
        wtExp = eeeg_pkg::RST_WAIT;
        enExp = ~np[3:0];
        repeat (12) begin
            ra = 8'h30 + 8'($random(seed) & 15);
            rdat = 8'($random(seed));
            wr(ra, rdat);
            if (ra == 8'h32) wtExp[15:8] = rdat;
            if (ra == 8'h33) wtExp[7:0] = rdat;
            if (ra == 8'h35) enExp = rdat[3:0];
            rd(ra, expByte(ra, wtExp, enExp));
        end
        w = ($random(seed) & 3) + 2;
        wr(8'h32, 8'h00);
        wr(8'h33, 8'(w));
        rd(8'h33, 8'(w));
        fastEthernetRateEee = 1'b1;
        transmitQueueEmpty = 4'hF;
        // the count must pass w, and the free tick phase adds up to one unit
        repeat (UNIT * w + 1) @(negedge sys_clk);
        chk({12'h000, lpiRequest}, 16'h0000);
        k = 0;
        while (lpiRequest !== 4'hF && k < UNIT) begin
            @(negedge sys_clk);
            k++;
        end
        chk({12'h000, lpiRequest}, 16'h000F);
        frameEnqueue = 4'h1;
        @(negedge sys_clk);
        frameEnqueue = 4'h0;
        chk({12'h000, lpiRequest}, 16'h000E);
        repeat (UNIT * w) @(negedge sys_clk);
        chk({12'h000, lpiRequest}, 16'h000E);
        fastEthernetRateEee = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk({12'h000, lpiRequest}, 16'h0000);
        // a wake of exactly the threshold is not late, one cycle more is
        phyWaking = 4'h2;
        repeat (16'h0201) @(negedge sys_clk);
        phyWaking = 4'h0;
        repeat (3) @(negedge sys_clk);
        chk(wakeupErrorCount, 16'h0000);
        phyWaking = 4'h2;
        repeat (16'h0202) @(negedge sys_clk);
        phyWaking = 4'h0;
        repeat (3) @(negedge sys_clk);
        chk(wakeupErrorCount, 16'h0001);
        phyWaking = 4'h5;
        repeat (16'h0202) @(negedge sys_clk);
        phyWaking = 4'h0;
        repeat (3) @(negedge sys_clk);
        chk(wakeupErrorCount, 16'h0003);
        stop_test;
    end
endmodule : tb
